// ===== inc/cal_pkg.sv
`default_nettype none
package cal_pkg;
  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int REG_W = 16;
  localparam int NREG = 9;
  localparam int SLOT_W = 4;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_LOCK_SEARCH = 10'h13B;
  localparam logic [IDX_W-1:0] IDX_LOCK_ADDR_LOW = 10'h13C;
  localparam logic [IDX_W-1:0] IDX_LOCK_ADDR_MID = 10'h13D;
  localparam logic [IDX_W-1:0] IDX_LOCK_ADDR_HIGH = 10'h13E;
  localparam logic [IDX_W-1:0] IDX_LOCK_FILTER_ID = 10'h13F;
  localparam logic [IDX_W-1:0] IDX_COUNTER_COMMAND = 10'h140;
  localparam logic [IDX_W-1:0] IDX_COUNTER_COMMAND_UPPER = 10'h141;
  localparam logic [IDX_W-1:0] IDX_COUNTER_RESULT_LOW = 10'h142;
  localparam logic [IDX_W-1:0] IDX_COUNTER_RESULT_HIGH = 10'h143;

  // slot of each register inside the decoded window
  localparam logic [SLOT_W-1:0] SLOT_SEARCH = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_ADDR_LOW = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_ADDR_MID = 4'h2;
  localparam logic [SLOT_W-1:0] SLOT_ADDR_HIGH = 4'h3;
  localparam logic [SLOT_W-1:0] SLOT_FILTER_ID = 4'h4;
  localparam logic [SLOT_W-1:0] SLOT_COMMAND = 4'h5;
  localparam logic [SLOT_W-1:0] SLOT_COMMAND_UPPER = 4'h6;
  localparam logic [SLOT_W-1:0] SLOT_RESULT_LOW = 4'h7;
  localparam logic [SLOT_W-1:0] SLOT_RESULT_HIGH = 4'h8;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int PORT_W = 3;
  localparam int FID_W = 4;
  localparam int TGT_W = 6;
  localparam int STA_W = 48;
  localparam int CNT_W = 32;
  localparam int BUSY_BIT = 7;
  localparam int OP_BIT = 6;
  localparam logic RST_BIT = 1'b0;
  localparam logic [REG_W-1:0] RST_REG = 16'h0000;
  localparam logic [PORT_W-1:0] RST_PORT = 3'h0;
  localparam logic [FID_W-1:0] RST_FID = 4'h0;
  localparam logic [TGT_W-1:0] RST_TGT = 6'h00;
  localparam logic [STA_W-1:0] RST_STA = 48'h000000000000;
  localparam logic [CNT_W-1:0] RST_CNT = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_DATA = 32'h00000000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_WAIT = 2'b11
  } cal_state_t;
endpackage : cal_pkg
`default_nettype wire

// ===== logic/cal_apb_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cal_apb_decode import cal_pkg::*; (
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic [NREG-1:0] hit,
  output logic [SLOT_W-1:0] slot,
  output logic mapped,
  output logic setup_rd,
  output logic setup_any,
  output logic access_wr
);
  // ----------------------------------------------------------------
  // word decode
  // ----------------------------------------------------------------
  wire logic aligned;
  wire logic [IDX_W-1:0] word_idx;
  wire logic [IDX_W-1:0] offset_idx;

  assign aligned = (paddr[1:0] == WORD_ALIGN);
  assign word_idx = paddr[ADDR_W-1:2];
  assign offset_idx = word_idx - IDX_LOCK_SEARCH;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_hit
      assign hit[gi] = aligned && (word_idx == IDX_W'(IDX_LOCK_SEARCH + gi));
    end
  endgenerate

  // ----------------------------------------------------------------
  // phase qualifiers
  // ----------------------------------------------------------------
  assign mapped = |hit;
  assign slot = mapped ? offset_idx[SLOT_W-1:0] : SLOT_SEARCH;
  assign setup_any = psel && !penable;
  assign setup_rd = setup_any && !pwrite;
  // no wait states, so the access phase is the write edge
  assign access_wr = psel && penable && pwrite && mapped;
endmodule : cal_apb_decode
`default_nettype wire

// ===== logic/cal_engine.sv
`timescale 1ns/1ps
`default_nettype none
module cal_engine import cal_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic op_renew,
  input wire logic [TGT_W-1:0] target_index,
  input wire logic cnt_done,
  input wire logic [CNT_W-1:0] cnt_value,
  output logic busy,
  output logic cnt_req,
  output logic cnt_renew,
  output logic [TGT_W-1:0] cnt_index,
  output logic [CNT_W-1:0] result
);
  // ----------------------------------------------------------------
  // state and latched command
  // ----------------------------------------------------------------
  cal_state_t state_ff, nxt_state;
  logic op_ff;
  logic [TGT_W-1:0] tgt_ff;
  logic [CNT_W-1:0] result_ff;
  wire logic take;
  wire logic finish;
  wire logic load_result;

  assign take = start && (state_ff == ST_IDLE);
  assign finish = (state_ff == ST_WAIT) && cnt_done;
  // renew gives no value, so the last fetched result stays readable
  assign load_result = finish && !op_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (take) nxt_state = ST_REQ;
      ST_REQ: nxt_state = ST_WAIT;
      ST_WAIT: if (cnt_done) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      op_ff <= RST_BIT;
      tgt_ff <= RST_TGT;
      result_ff <= RST_CNT;
    end else begin
      state_ff <= nxt_state;
      if (take) op_ff <= op_renew;
      if (take) tgt_ff <= target_index;
      if (load_result) result_ff <= cnt_value;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy = (state_ff != ST_IDLE);
  assign cnt_req = (state_ff == ST_REQ);
  assign cnt_renew = op_ff;
  assign cnt_index = tgt_ff;
  assign result = result_ff;
endmodule : cal_engine
`default_nettype wire

// ===== logic/cal_top.sv
// How it works
// - lock_addr_low at index 13C returns locked address bits 15 to 0
// - lock_addr_mid returns locked address bits 31 to 16
// - lock_addr_high at index 13E returns locked address bits 47 to 32
// - lock_filter_id at 13F returns 4-bit filtering id, upper bits read zero
// - software writes 3-bit port code; readback shows that port's lock data
// - command bit 7 reads 0 when engine idle, 1 while busy
// - command bit 6 picks indirect counter read (0) or port renew (1)
// - in read mode bits 5 to 0 give the counter address
// - in renew mode bits 5 to 0 give the ports to renew
// - counter_result_low at 142 returns fetched value bits 15 to 0
// - counter_result_high at 143 returns fetched value bits 31 to 16
`timescale 1ns/1ps
`default_nettype none
module cal_top import cal_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PORT_W-1:0] lock_port,
  input wire logic [STA_W-1:0] lock_station_in,
  input wire logic [FID_W-1:0] lock_fid_in,
  output logic cnt_req,
  output logic cnt_renew,
  output logic [TGT_W-1:0] cnt_index,
  input wire logic cnt_done,
  input wire logic [CNT_W-1:0] cnt_value
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [NREG-1:0] hit;
  logic [SLOT_W-1:0] slot;
  logic mapped;
  logic setup_rd;
  logic setup_any;
  logic access_wr;

  cal_apb_decode u_decode (
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .hit(hit),
    .slot(slot),
    .mapped(mapped),
    .setup_rd(setup_rd),
    .setup_any(setup_any),
    .access_wr(access_wr)
  );

  wire logic wr_search;
  wire logic wr_command;
  wire logic start_req;

  assign wr_search = access_wr && hit[SLOT_SEARCH];
  assign wr_command = access_wr && hit[SLOT_COMMAND];
  // a go written while busy is dropped; software must poll first
  assign start_req = wr_command && pwdata[BUSY_BIT];

  // ----------------------------------------------------------------
  // lock search port and readback capture
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] lock_port_ff;
  logic [STA_W-1:0] station_ff;
  logic [FID_W-1:0] fid_ff;

  // registered every cycle, so the low, mid and high words are separate samples, not one snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_port_ff <= RST_PORT;
      station_ff <= RST_STA;
      fid_ff <= RST_FID;
    end else begin
      if (wr_search) lock_port_ff <= pwdata[PORT_W-1:0];
      station_ff <= lock_station_in;
      fid_ff <= lock_fid_in;
    end
  end

  assign lock_port = lock_port_ff;

  // ----------------------------------------------------------------
  // counter engine
  // ----------------------------------------------------------------
  logic busy;
  logic [CNT_W-1:0] result;
  logic [TGT_W-1:0] cmd_tgt_ff;
  logic cmd_op_ff;
  wire logic cmd_load;

  // field keeps its value while busy so a readback matches the job
  assign cmd_load = wr_command && !busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_op_ff <= RST_BIT;
      cmd_tgt_ff <= RST_TGT;
    end else begin
      if (cmd_load) cmd_op_ff <= pwdata[OP_BIT];
      if (cmd_load) cmd_tgt_ff <= pwdata[TGT_W-1:0];
    end
  end

  cal_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_req),
    .op_renew(pwdata[OP_BIT]),
    .target_index(pwdata[TGT_W-1:0]),
    .cnt_done(cnt_done),
    .cnt_value(cnt_value),
    .busy(busy),
    .cnt_req(cnt_req),
    .cnt_renew(cnt_renew),
    .cnt_index(cnt_index),
    .result(result)
  );

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  logic [REG_W-1:0] reg_view [NREG];

  assign reg_view[SLOT_SEARCH] = REG_W'(lock_port_ff);
  assign reg_view[SLOT_ADDR_LOW] = station_ff[15:0];
  assign reg_view[SLOT_ADDR_MID] = station_ff[31:16];
  assign reg_view[SLOT_ADDR_HIGH] = station_ff[47:32];
  assign reg_view[SLOT_FILTER_ID] = REG_W'(fid_ff);
  assign reg_view[SLOT_COMMAND] = REG_W'({busy, cmd_op_ff, cmd_tgt_ff});
  assign reg_view[SLOT_COMMAND_UPPER] = RST_REG;
  assign reg_view[SLOT_RESULT_LOW] = result[15:0];
  assign reg_view[SLOT_RESULT_HIGH] = result[31:16];

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] prdata_ff;
  logic pslverr_ff;
  wire logic [DATA_W-1:0] rd_word;

  assign rd_word = mapped ? DATA_W'(reg_view[slot]) : RST_DATA;

  // sampled in setup, so the access phase answers with zero wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= RST_DATA;
      pslverr_ff <= RST_BIT;
    end else begin
      if (setup_rd) prdata_ff <= rd_word;
      if (setup_any) pslverr_ff <= !mapped;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff && psel && penable;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire logic rd_acc;
  logic [TGT_W-1:0] start_tgt_ff;
  logic start_op_ff;
  logic started_ff;

  assign rd_acc = psel && penable && !pwrite;

  // helper that remembers the last taken command for checks below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_tgt_ff <= RST_TGT;
      start_op_ff <= RST_BIT;
      started_ff <= RST_BIT;
    end else begin
      started_ff <= start_req && !busy;
      if (start_req && !busy) start_tgt_ff <= pwdata[TGT_W-1:0];
      if (start_req && !busy) start_op_ff <= pwdata[OP_BIT];
    end
  end

  a_addr_low_read: assert property (
    rd_acc && hit[SLOT_ADDR_LOW] |->
      prdata == DATA_W'($past(station_ff[15:0]))
  ) else $error("lock address low word wrong");

  a_addr_mid_read: assert property (
    rd_acc && hit[SLOT_ADDR_MID] |->
      prdata == DATA_W'($past(station_ff[31:16]))
  ) else $error("lock address mid word wrong");

  a_addr_high_read: assert property (
    rd_acc && hit[SLOT_ADDR_HIGH] |->
      prdata == DATA_W'($past(station_ff[47:32]))
  ) else $error("lock address high word wrong");

  a_fid_read: assert property (
    rd_acc && hit[SLOT_FILTER_ID] |->
      prdata[DATA_W-1:FID_W] == '0 && prdata[FID_W-1:0] == $past(fid_ff)
  ) else $error("filter id readback wrong");

  a_search_port_sel: assert property (
    wr_search |=> lock_port == $past(pwdata[PORT_W-1:0])
      ##1 station_ff == $past(lock_station_in)
  ) else $error("lock search port not applied");

  a_busy_bit_read: assert property (
    rd_acc && hit[SLOT_COMMAND] |->
      prdata[BUSY_BIT] == $past(busy)
  ) else $error("busy bit readback wrong");

  a_busy_on_start: assert property (
    start_req && !busy |=> busy [*2]
  ) else $error("busy not raised on start");

  a_op_select: assert property (
    started_ff |-> cnt_req && cnt_renew == start_op_ff
  ) else $error("operation select not applied");

  a_read_index: assert property (
    started_ff && !start_op_ff |-> cnt_index == start_tgt_ff && !cnt_renew
  ) else $error("counter address not applied");

  a_renew_ports: assert property (
    started_ff && start_op_ff |-> cnt_index == start_tgt_ff && cnt_renew
  ) else $error("renew port field not applied");

  sequence s_read_done;
    busy && !cnt_req && !cnt_renew && cnt_done;
  endsequence

  a_result_low: assert property (
    s_read_done |=> result[15:0] == $past(cnt_value[15:0])
  ) else $error("result low word not loaded");

  a_result_high: assert property (
    s_read_done |=> result[31:16] == $past(cnt_value[31:16])
  ) else $error("result high word not loaded");

  a_busy_clears: assert property (
    busy && !cnt_req && cnt_done |=> !busy
  ) else $error("busy did not clear");

  a_result_holds: assert property (
    !busy && !start_req |=> $stable(result)
  ) else $error("result changed while idle");

  a_single_req: assert property (
    cnt_req |=> !cnt_req throughout (busy [*1])
  ) else $error("request pulse longer than one cycle");

  a_unmapped_err: assert property (
    psel && penable && $past(setup_any) && !mapped |-> pslverr
  ) else $error("unmapped access not flagged");

  // ----------------------------------------------------------------
  // readback and hold checks
  // ----------------------------------------------------------------

  a_search_read: assert property (
    rd_acc && hit[SLOT_SEARCH] |->
      prdata == DATA_W'($past(lock_port_ff))
  ) else $error("lock search port readback wrong");

  a_cmd_read: assert property (
    rd_acc && hit[SLOT_COMMAND] |->
      prdata == DATA_W'({$past(busy), $past(cmd_op_ff), $past(cmd_tgt_ff)})
  ) else $error("command readback wrong");

  a_upper_reads_zero: assert property (
    rd_acc && hit[SLOT_COMMAND_UPPER] |-> prdata == RST_DATA
  ) else $error("reserved command word not zero");

  a_result_low_read: assert property (
    rd_acc && hit[SLOT_RESULT_LOW] |->
      prdata == DATA_W'($past(result[15:0]))
  ) else $error("result low readback wrong");

  a_result_high_read: assert property (
    rd_acc && hit[SLOT_RESULT_HIGH] |->
      prdata == DATA_W'($past(result[31:16]))
  ) else $error("result high readback wrong");

  a_unmapped_zero: assert property (
    rd_acc && $past(setup_any) && !mapped |-> prdata == RST_DATA
  ) else $error("unmapped read not zero");

  a_mapped_no_err: assert property (
    psel && penable && mapped |-> !pslverr
  ) else $error("error flagged on mapped access");

  a_cmd_load_idle: assert property (
    wr_command && !busy |=> cmd_op_ff == $past(pwdata[OP_BIT])
      && cmd_tgt_ff == $past(pwdata[TGT_W-1:0])
  ) else $error("command fields not loaded");

  a_busy_write_drop: assert property (
    wr_command && busy |=> $stable(cmd_op_ff) && $stable(cmd_tgt_ff)
  ) else $error("command changed while busy");

  a_link_stable: assert property (
    busy && $past(busy) |-> $stable(cnt_index) && $stable(cnt_renew)
  ) else $error("link fields moved during a job");

  a_go_needs_idle: assert property (
    cnt_req |-> $past(start_req) && !$past(busy)
  ) else $error("request without an accepted go");

  a_done_ignored_idle: assert property (
    !busy && !start_req |=> !busy
  ) else $error("engine woke up without a go");

  a_result_kept_renew: assert property (
    busy && cnt_renew && !cnt_req |=> $stable(result)
  ) else $error("renew job changed the result");

  a_lock_port_hold: assert property (
    !wr_search |=> $stable(lock_port)
  ) else $error("lock port moved without a write");

  c_read_access: cover property (
    started_ff && !start_op_ff ##[1:20] !busy
  );

  c_renew_access: cover property (
    started_ff && start_op_ff ##[1:20] !busy
  );

  c_lock_readback: cover property (
    wr_search ##[1:10] rd_acc && hit[SLOT_ADDR_HIGH]
  );

  c_busy_poll: cover property (
    rd_acc && hit[SLOT_COMMAND] && prdata[BUSY_BIT]
  );

  c_dropped_go: cover property (
    wr_command && busy && pwdata[BUSY_BIT]
  );
endmodule : cal_top
`default_nettype wire

// ===== sim/counter_access_lock_readback_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module counter_access_lock_readback_tb_top import cal_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic cnt_req, cnt_renew, cnt_done;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdata, r;
  logic [PORT_W-1:0] lock_port;
  logic [STA_W-1:0] lock_station_in;
  logic [FID_W-1:0] lock_fid_in;
  logic [TGT_W-1:0] cnt_index;
  logic [CNT_W-1:0] cnt_value, job_val, res;
  logic [63:0] rr;
  logic [DATA_W+1:0] rd_q[$];
  logic [DATA_W+1:0] e;
  logic [TGT_W:0] job_q[$];
  logic [TGT_W:0] j;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 94;

  cal_top dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lock_port(lock_port), .lock_station_in(lock_station_in),
    .lock_fid_in(lock_fid_in), .cnt_req(cnt_req), .cnt_renew(cnt_renew),
    .cnt_index(cnt_index), .cnt_done(cnt_done), .cnt_value(cnt_value));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic cmp_rd(input logic [DATA_W:0] want, input logic [DATA_W:0] got);
    n_tests++;
    if (got !== want) begin
      n_errors++;
      $display("BAD %0t read got %h want %h", $time, got, want);
    end
  endtask : cmp_rd

  task automatic cmp_link(input logic [TGT_W:0] want, input logic [TGT_W:0] got);
    n_tests++;
    if (got !== want) begin
      n_errors++;
      $display("BAD %0t link got %h want %h", $time, got, want);
    end
  endtask : cmp_link

  function automatic logic [ADDR_W-1:0] ad(input logic [IDX_W-1:0] i);
    return {i, 2'h0};
  endfunction : ad

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // this wait ends on the first cycle with pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // expectation goes on the queue before the transfer starts
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x,
                    input logic err = 1'b0, input logic c = 1'b1);
    rd_q.push_back({c, err, x});
    apb(1'b0, a, $random(seed));
  endtask : rd

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      rd(ad(IDX_COUNTER_COMMAND), '0, 1'b0, 1'b0);
      k++;
    end while (rdata[BUSY_BIT] !== 1'b0 && k < 60);
    if (k >= 60) begin
      n_errors++;
      $display("BAD %0t engine stuck busy", $time);
    end
  endtask : wait_idle

  task automatic go(input logic op, input logic [TGT_W-1:0] ix);
    wait_idle();
    r = $random(seed);
    job_val = r;
    job_q.push_back({op, ix});
    apb(1'b1, ad(IDX_COUNTER_COMMAND), {r[31:8], 1'b1, op, ix});
    rd(ad(IDX_COUNTER_COMMAND), {24'h0, 1'b1, op, ix});
    // a second go while busy must be dropped whole
    apb(1'b1, ad(IDX_COUNTER_COMMAND), {24'h0, 1'b1, ~op, ~ix});
    wait_idle();
    rd(ad(IDX_COUNTER_COMMAND), {24'h0, 1'b0, op, ix});
    if (!op) res = r;
    rd(ad(IDX_COUNTER_RESULT_LOW), {16'h0, res[15:0]});
    rd(ad(IDX_COUNTER_RESULT_HIGH), {16'h0, res[31:16]});
  endtask : go

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // monitor and counter far side
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      if (e[DATA_W+1]) cmp_rd(e[DATA_W:0], {pslverr, prdata});
    end
    if (cnt_req === 1'b1) begin
      if (job_q.size() > 0) j = job_q.pop_front();
      else j = 'x;
      cmp_link(j, {cnt_renew, cnt_index});
    end
  end

  // answers never sooner than four cycles so the second go still lands while busy
  initial begin
    cnt_done = 1'b0;
    cnt_value = '0;
    forever begin
      @(posedge pclk);
      cnt_done <= 1'b0;
      cnt_value <= $random(seed);
      if (cnt_req === 1'b1) begin
        repeat (($random(seed) & 7) + 4) @(posedge pclk);
        cnt_done <= 1'b1;
        cnt_value <= job_val;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = '0;
    pwdata = '0;
    lock_station_in = '0;
    lock_fid_in = '0;
    res = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NREG; i++) rd(ad(IDX_LOCK_SEARCH + 10'(i)), 32'h0);
    for (int p = 0; p < 8; p++) begin
      r = $random(seed);
      apb(1'b1, ad(IDX_LOCK_SEARCH), {r[31:3], 3'(p)});
      @(negedge pclk);
      cmp_link({4'h0, 3'(p)}, {4'h0, lock_port});
      @(posedge pclk);
      rr = {$random(seed), $random(seed)};
      lock_station_in <= rr[47:0];
      lock_fid_in <= rr[51:48];
      repeat (2) @(posedge pclk);
      apb(1'b1, ad(IDX_LOCK_ADDR_LOW), 32'hFFFFFFFF);
      rd(ad(IDX_LOCK_ADDR_LOW), {16'h0, rr[15:0]});
      rd(ad(IDX_LOCK_ADDR_MID), {16'h0, rr[31:16]});
      rd(ad(IDX_LOCK_ADDR_HIGH), {16'h0, rr[47:32]});
      rd(ad(IDX_LOCK_FILTER_ID), {28'h0, rr[51:48]});
      rd(ad(IDX_LOCK_SEARCH), {29'h0, 3'(p)});
    end
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      go(i[0], (i < 2) ? {TGT_W{i[0]}} : r[5:0]);
    end
    // fields load without a go when bit 7 is clear
    apb(1'b1, ad(IDX_COUNTER_COMMAND), 32'h0000002A);
    rd(ad(IDX_COUNTER_COMMAND), 32'h0000002A);
    rd(ad(IDX_COUNTER_RESULT_LOW), {16'h0, res[15:0]});
    apb(1'b1, 12'h4E8, 32'hFFFFFFFF);
    rd(12'h4E8, 32'h0, 1'b1);
    rd(12'h510, 32'h0, 1'b1);
    rd(12'h4F1, 32'h0, 1'b1);
    rd(ad(IDX_COUNTER_COMMAND_UPPER), 32'h0);
    // reset in the middle of a job
    job_q.push_back({1'b0, 6'h15});
    apb(1'b1, ad(IDX_COUNTER_COMMAND), 32'h00000095);
    repeat (2) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    cmp_link('0, {4'h0, lock_port});
    rd(ad(IDX_COUNTER_COMMAND), 32'h0);
    rd(ad(IDX_COUNTER_RESULT_LOW), 32'h0);
    repeat (20) @(posedge pclk);
    close_out();
  end
endmodule : counter_access_lock_readback_tb_top
`default_nettype wire
